// >>> hw/irq_host_ctrl.sv
// Operation
// - host never asserts both strobes, never acknowledges while selecting
// - host sends a fresh preselect before loading each level
// - host holds first acknowledge until wait goes high
// - host stretches only the first acknowledge while wait is low; later acknowledges end after the counted width
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module irq_host_ctrl
  import irq_host_pkg::*;
#(
  parameter int SETUP_CYCLES = SETUP_CYC,
  parameter int STROBE_CYCLES = STROBE_CYC,
  parameter int RECOVER_CYCLES = RECOVER_CYC,
  parameter int ACK_CYCLES = ACK_CYC,
  parameter logic [7:0] RESP_SEL_CMD = RESP_SEL_BASE
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire irq_host_pkg::pins_in_s pins_i,
  output irq_host_pkg::pins_out_s pins_o
);
  import irq_host_pkg::*;

  // ==========================================
  // pin input synchronisers
  pins_in_s syn;
  logic [10:0] syn_vec;

  pin_sync #(
    .W(11),
    .INIT(11'h600)
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .raw(pins_i),
    .stable(syn_vec)
  );

  assign syn = syn_vec;

  // ==========================================
  // state
  state_e state_r;
  state_e state_nxt;
  pins_out_s pins_r;
  pins_out_s pins_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [2:0] op_r;
  logic [2:0] op_nxt;
  logic [7:0] result_r;
  logic [7:0] result_nxt;
  logic first_r;
  logic first_nxt;
  logic refused_r;
  logic refused_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // ==========================================
  // software port decode
  wire op_hit = wr_en && (addr == OFF_OP);
  wire idle = (state_r == ST_IDLE);
  wire op_go = op_hit && idle;
  wire op_refused = op_hit && !idle;
  wire status_rd = rd_en && (addr == OFF_STATUS);
  wire [2:0] op_in = wdata[OP_MSB:OP_LSB];
  wire [7:0] byte_in = wdata[7:0];
  wire is_read = (op_r == OP_RD_STATUS) || (op_r == OP_RD_DATA);
  wire cnt_done = (cnt_r == 8'h00);
  wire [7:0] cnt_dec = cnt_done ? 8'h00 : cnt_r - 8'h01;
  wire [7:0] resp_sel_byte = RESP_SEL_CMD | {5'h00, wdata[LEVEL_MSB:0]};
  // first acknowledge ends only after wait rose
  wire ack_may_end = cnt_done
                  && (!first_r || (syn.ack_wait_n && !syn.response_active_n));

  wire [7:0] status_byte = {2'b00, refused_r, first_r, !syn.ack_wait_n,
                            !syn.response_active_n, syn.group_irq, !idle};
  wire [7:0] rd_sel = (addr == OFF_RESULT) ? result_r
                    : (addr == OFF_STATUS) ? status_byte : 8'h00;

  // ==========================================
  // pin sequencer
  always_comb
  begin
    state_nxt = state_r;
    pins_nxt = pins_r;
    cnt_nxt = cnt_dec;
    op_nxt = op_r;
    result_nxt = result_r;
    first_nxt = first_r;
    case (state_r)
      ST_IDLE:
      begin
        if (op_go)
        begin
          op_nxt = op_in;
          if (op_in == OP_ACK)
          begin
            pins_nxt.ack_pulse_n = 1'b0;
            pins_nxt.chip_select_n = 1'b1;
            pins_nxt.data_oe_n = 1'b1;
            first_nxt = syn.response_active_n;
            cnt_nxt = 8'(ACK_CYCLES - 1);
            state_nxt = ST_ACK;
          end
          else
          begin
            pins_nxt.chip_select_n = 1'b0;
            pins_nxt.port_select = (op_in == OP_WR_CMD) || (op_in == OP_RD_STATUS)
                                || (op_in == OP_RESP_SEL);
            pins_nxt.data = (op_in == OP_RESP_SEL) ? resp_sel_byte : byte_in;
            pins_nxt.data_oe_n = (op_in == OP_RD_STATUS) || (op_in == OP_RD_DATA);
            cnt_nxt = 8'(SETUP_CYCLES - 1);
            state_nxt = ST_SETUP;
          end
        end
      end
      ST_SETUP:
      begin
        if (cnt_done)
        begin
          // exactly one strobe at a time
          pins_nxt.read_strobe_n = !is_read;
          pins_nxt.store_strobe_n = is_read;
          cnt_nxt = 8'(STROBE_CYCLES - 1);
          state_nxt = ST_STROBE;
        end
      end
      ST_STROBE:
      begin
        if (cnt_done)
        begin
          pins_nxt.read_strobe_n = 1'b1;
          pins_nxt.store_strobe_n = 1'b1;
          if (is_read)
          begin
            result_nxt = syn.data;
          end
          cnt_nxt = 8'(RECOVER_CYCLES - 1);
          state_nxt = ST_RECOVER;
        end
      end
      ST_ACK:
      begin
        if (ack_may_end)
        begin
          pins_nxt.ack_pulse_n = 1'b1;
          result_nxt = syn.data;
          cnt_nxt = 8'(RECOVER_CYCLES - 1);
          state_nxt = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        if (cnt_done)
        begin
          pins_nxt.chip_select_n = 1'b1;
          pins_nxt.port_select = 1'b0;
          pins_nxt.data_oe_n = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        pins_nxt = PINS_IDLE;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // refused flag: a refusal wins over the clearing read
  assign refused_nxt = op_refused ? 1'b1 : (status_rd ? 1'b0 : refused_r);
  assign rdata_nxt = rd_en ? {24'h000000, rd_sel} : 32'h00000000;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= ST_IDLE;
      pins_r <= PINS_IDLE;
      cnt_r <= 8'h00;
      op_r <= OP_WR_CMD;
      result_r <= 8'h00;
      first_r <= 1'b0;
      refused_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      state_r <= state_nxt;
      pins_r <= pins_nxt;
      cnt_r <= cnt_nxt;
      op_r <= op_nxt;
      result_r <= result_nxt;
      first_r <= first_nxt;
      refused_r <= refused_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign pins_o = pins_r;
  assign rdata = rdata_r;

  // ==========================================
  // checks
  a_strobe_exclusive: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !(!pins_r.read_strobe_n && !pins_r.store_strobe_n))
    else $error("both strobes low");

  a_ack_not_selected: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !pins_r.ack_pulse_n |-> pins_r.chip_select_n)
    else $error("acknowledge while chip selected");

  a_resp_sel_byte: assert property (
    @(posedge core_clk) disable iff (!nrst)
    op_go && (op_in == OP_RESP_SEL)
    |=> pins_r.port_select && !pins_r.chip_select_n
        && (pins_r.data == $past(resp_sel_byte)))
    else $error("preselect command not driven on control port");

  a_first_ack_hold: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $rose(pins_r.ack_pulse_n) && first_r |-> $past(syn.ack_wait_n))
    else $error("first acknowledge released while wait low");

  a_ack_min_width: assert property (
    @(posedge core_clk) disable iff (!nrst)
    $fell(pins_r.ack_pulse_n) |-> !pins_r.ack_pulse_n [*8])
    else $error("acknowledge pulse too short");

  a_wait_stretch: assert property (
    @(posedge core_clk) disable iff (!nrst)
    !pins_r.ack_pulse_n && first_r && !syn.ack_wait_n |=> !pins_r.ack_pulse_n)
    else $error("acknowledge ended while not ready");

endmodule

// >>> hw/irq_host_pkg.sv
package irq_host_pkg;

  // ==========================================
  // software port map
  localparam logic [7:0] OFF_OP = 8'h00;
  localparam logic [7:0] OFF_RESULT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  // ==========================================
  // op field of a write to OFF_OP
  localparam int OP_LSB = 8;
  localparam int OP_MSB = 10;
  localparam int LEVEL_MSB = 2;
  localparam logic [2:0] OP_WR_CMD = 3'h0;
  localparam logic [2:0] OP_WR_DATA = 3'h1;
  localparam logic [2:0] OP_RD_STATUS = 3'h2;
  localparam logic [2:0] OP_RD_DATA = 3'h3;
  localparam logic [2:0] OP_ACK = 3'h4;
  localparam logic [2:0] OP_RESP_SEL = 3'h5;

  // response memory preselect opcode base, level in low three bits
  localparam logic [7:0] RESP_SEL_BASE = 8'he0;

  // ==========================================
  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_IRQ = 1;
  localparam int ST_RESP = 2;
  localparam int ST_WAIT = 3;
  localparam int ST_FIRST = 4;
  localparam int ST_REFUSED = 5;

  // ==========================================
  // pin timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_SETUP_NS = 50;
  localparam int T_STROBE_NS = 300;
  localparam int T_RECOVER_NS = 100;
  localparam int T_ACK_NS = 300;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_CYC = (T_ACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================
  // pin carriers
  typedef struct packed {
    logic chip_select_n;
    logic port_select;
    logic read_strobe_n;
    logic store_strobe_n;
    logic ack_pulse_n;
    logic [7:0] data;
    logic data_oe_n;
  } pins_out_s;

  typedef struct packed {
    logic ack_wait_n;
    logic response_active_n;
    logic group_irq;
    logic [7:0] data;
  } pins_in_s;

  localparam pins_out_s PINS_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 1'b1};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_RECOVER = 3'b011,
    ST_ACK = 3'b100
  } state_e;

endpackage

// >>> hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 11,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] stable
);
  // ==========================================
  // three stages, accept when last two agree
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic out_r;
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          s1_r <= INIT[i];
          s2_r <= INIT[i];
          s3_r <= INIT[i];
          out_r <= INIT[i];
        end
        else
        begin
          s1_r <= raw[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
          begin
            out_r <= s3_r;
          end
        end
      end
      assign stable[i] = out_r;
    end
  endgenerate
endmodule

// >>> sim/irq_dev_model.sv
`timescale 1ns/1ps
module irq_dev_model
  import irq_host_pkg::*;
(
  input wire irq_host_pkg::pins_out_s h,
  input wire logic [7:0] bus,
  input wire logic [7:0] irq_in,
  input wire logic slow,
  output irq_host_pkg::pins_in_s d,
  output int faults
);
  // ====
  // device state
  logic [7:0] cmd_r, mode_r, mask_r, req_r, isr_r, prev_r, hold_r;
  logic [7:0] mem [8][4];
  logic [1:0] cnt [8];
  logic [1:0] wp, rp, dst;
  logic [2:0] lvl, sel, low_r;
  logic wait_n, rip_n, drv;
  wire [2:0] vl = mode_r[1] ? 3'h0 : sel;
  // lowest-priority input, fixed mode uses input 7
  wire [2:0] rb = mode_r[0] ? low_r : 3'h7;
  wire cs = !h.chip_select_n && h.ack_pulse_n;
  // fence: rotating blocks all, fixed only lower
  wire [7:0] low_set = isr_r & (~isr_r + 8'h01);
  wire [7:0] fence = mode_r[0] ? {8{~|isr_r}} : low_set - 8'h01;
  wire [7:0] st = {~|(req_r & ~mask_r), 1'b1, mode_r[0], mode_r[2], 4'h0};
  wire girq = |(req_r & ~mask_r & fence) && !mode_r[2];
  wire rd_on = cs && !h.read_strobe_n;
  wire [7:0] val = rd_on ? (h.port_select ? st : isr_r) : mem[vl][rp];
  assign drv = rd_on || (!h.ack_pulse_n && !rip_n);
  always @*
    if (drv)
      hold_r = ~val;
  assign d = {wait_n, rip_n, girq, drv ? val : hold_r};
  initial
  begin
    {mode_r, mask_r} = 16'h00ff;
    {req_r, isr_r, prev_r, cmd_r, wp, rp, dst, lvl, sel} = 52'h0;
    {hold_r, wait_n, rip_n} = 10'h16b;
    faults = 0;
    low_r = 3'h7;
    foreach (cnt[i])
      cnt[i] = 2'h0;
  end
  // rotation when the serviced bit clears
  always @(negedge (|isr_r))
    low_r = sel;
  always @(irq_in)
  begin
    req_r = req_r | (irq_in & ~prev_r);
    prev_r = irq_in;
  end
  always @(posedge h.store_strobe_n)
  begin
    if (!h.read_strobe_n)
      faults++;
    if (cs && h.port_select)
    begin
      cmd_r = bus;
      if (bus[7:3] == RESP_SEL_BASE[7:3])
      begin
        {dst, lvl, wp} = {2'h2, bus[2:0], 2'h0};
        cnt[bus[2:0]] = 2'h0;
      end
      else if (bus == 8'hb0)
        dst = 2'h1;
      else if (bus == 8'h00)
        {mode_r, mask_r} = 16'h00ff;
      else if (bus[7:5] == 3'b100)
        mode_r[4:0] = bus[4:0];
    end
    else if (cs && dst == 2'h1)
      mask_r = bus;
    else if (cs && dst == 2'h2)
    begin
      mem[lvl][wp] = bus;
      if (wp > cnt[lvl])
        cnt[lvl] = wp;
      wp = wp + 2'h1;
    end
  end
  always @(negedge h.ack_pulse_n)
  begin
    if (!h.chip_select_n)
      faults++;
    if (rip_n)
    begin
      wait_n = 1'b0;
      #(slow ? 404 : 20);
      sel = 3'h0;
      for (int i = 8; i >= 1; i--)
        if (req_r[3'(rb + i)] && !mask_r[3'(rb + i)])
          sel = 3'(rb + i);
      {req_r[sel], isr_r[sel], rp} = 4'h4;
      {rip_n, wait_n} = 2'b01;
    end
    else
      rp = rp + 2'h1;
  end
  always @(posedge h.ack_pulse_n)
  begin
    if (!wait_n)
      faults++;
    if (rp == cnt[vl])
      rip_n = 1'b1;
  end
endmodule

// >>> sim/irq_host_ctrl_test.sv
`timescale 1ns/1ps
module irq_host_ctrl_test;
  import irq_host_pkg::*;
  logic core_clk, nrst, wr_en, rd_en, slow;
  logic [7:0] addr, irq_in;
  logic [31:0] wdata, rdata, v, st_or;
  pins_out_s pins_o;
  pins_in_s pins_i, dev;
  int num_errors = 0;
  int cmp_count = 0;
  wire [7:0] bus = !pins_o.data_oe_n ? pins_o.data : dev.data;
  assign pins_i = {dev.ack_wait_n, dev.response_active_n, dev.group_irq, bus};

  irq_host_ctrl #(.SETUP_CYCLES(2), .STROBE_CYCLES(5), .RECOVER_CYCLES(2), .ACK_CYCLES(9))
    irq_host_ctrl_i (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pins_i(pins_i), .pins_o(pins_o));
  irq_dev_model irq_dev_model_i (.h(pins_o), .bus(bus), .irq_in(irq_in), .slow(slow),
    .d(dev), .faults());

  // ====
  // bus tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
    @(posedge core_clk);
  endtask
  task automatic poll();
    int n;
    n = 0;
    st_or = 32'h0;
    v = 32'h1;
    while (v[ST_BUSY] !== 1'b0 && n < 300)
    begin
      rd(OFF_STATUS, v);
      st_or = st_or | v;
      n++;
    end
    if (v[ST_BUSY] !== 1'b0)
      num_errors++;
  endtask
  task automatic op(input logic [2:0] c, input logic [7:0] b);
    wr(OFF_OP, {21'h0, c, b});
    poll();
  endtask
  task automatic summarize();
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ====
  // scenarios
  task automatic t_reset();
    chk(pins_o, PINS_IDLE);
    rd(8'h40, v);
    chk(v, 32'h0);
  endtask
  task automatic t_mode();
    op(OP_WR_CMD, 8'h85);
    chk(irq_dev_model_i.cmd_r, 8'h85);
    op(OP_RD_STATUS, 8'h00);
    rd(OFF_RESULT, v);
    chk(v[5:4], 2'h3);
    op(OP_WR_CMD, 8'h00);
    op(OP_RD_STATUS, 8'h00);
    rd(OFF_RESULT, v);
    chk(v[5:4], 2'h0);
  endtask
  task automatic t_refuse();
    wr(OFF_OP, {21'h0, OP_RD_STATUS, 8'h00});
    op(OP_WR_CMD, 8'h85);
    chk(st_or[ST_REFUSED], 1'b1);
    chk(irq_dev_model_i.cmd_r, 8'h00);
  endtask
  task automatic t_load();
    op(OP_WR_CMD, 8'hb0);
    op(OP_WR_DATA, 8'h00);
    chk(irq_dev_model_i.mask_r, 8'h00);
    op(OP_RESP_SEL, 8'h03);
    for (int i = 1; i < 6; i++)
      op(OP_WR_DATA, 8'ha0 + 8'(i));
    chk(irq_dev_model_i.cnt[3], 2'h3);
  endtask
  task automatic t_ack();
    logic [31:0] exp;
    exp = 32'ha4a3a2a5;
    irq_in[5] <= 1'b1;
    repeat (4) @(posedge core_clk);
    irq_in[3] <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(OFF_STATUS, v);
    chk(v[ST_IRQ], 1'b1);
    op(OP_WR_CMD, 8'h84);
    rd(OFF_STATUS, v);
    chk(v[ST_IRQ], 1'b0);
    op(OP_WR_CMD, 8'h80);
    rd(OFF_STATUS, v);
    chk(v[ST_IRQ], 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      slow <= (k == 0);
      @(posedge core_clk);
      op(OP_ACK, 8'h00);
      chk(st_or[ST_WAIT], k == 0);
      chk(v[ST_FIRST], k == 0);
      rd(OFF_RESULT, v);
      chk(v[7:0], exp[k*8+:8]);
    end
    op(OP_RD_DATA, 8'h00);
    rd(OFF_RESULT, v);
    chk(v[7:0], 8'h08);
    rd(OFF_STATUS, v);
    chk(v[ST_IRQ], 1'b0);
    irq_in[1] <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(OFF_STATUS, v);
    chk(v[ST_IRQ], 1'b1);
    op(OP_WR_CMD, 8'h82);
    op(OP_RESP_SEL, 8'h00);
    op(OP_WR_DATA, 8'h5c);
    op(OP_ACK, 8'h00);
    rd(OFF_RESULT, v);
    chk(v[7:0], 8'h5c);
    op(OP_RD_DATA, 8'h00);
    rd(OFF_RESULT, v);
    chk(v[7:0], 8'h0a);
    chk(irq_dev_model_i.faults, 0);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever
      #4 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (50000) @(posedge core_clk);
    num_errors++;
    summarize();
  end
  initial
  begin
    {nrst, wr_en, rd_en, slow, addr, irq_in, wdata} = 52'h0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_mode();
    t_refuse();
    t_load();
    t_ack();
    summarize();
  end
endmodule
